// [bench/host_model.sv]
// Host-bank stand-in: drives host events, flags and the command vector.
// Assumes the bench calls ev() from its own process on the same clock.
`timescale 1ns/1ns
`default_nettype none

module host_model (
	// Clock and service feedback
	input  wire logic                REF_CLK,
	input  wire logic                CMD_CLEAR,
	// Host-bank event group
	output host_port_pkg::host_evt_s HOST_EVT,
	output logic      [6:0]          HOST_VECTOR
);
	logic cmd_bit; // Host command bit of the vector register

	// Vector is a plain test pattern
	initial
	begin
		HOST_EVT = '0;
		HOST_VECTOR = 7'h2A;
		cmd_bit = 1'b0;
	end

	// Serviced command drops the host command bit
	always @(posedge REF_CLK)
		if (CMD_CLEAR)
			cmd_bit <= 1'b0;

	// One pulse, except 5 whose flags stay set; k: 0 load, 1 take, 2 init, 3 cmd set, 4 cmd clear, 5 flags
	task automatic ev(input int k, input logic [15:0] d);
		@(negedge REF_CLK);
		HOST_EVT.rx_data = d;
		HOST_EVT.rx_load = (k == 0);
		HOST_EVT.tx_take = (k == 1);
		HOST_EVT.init = (k == 2);
		HOST_EVT.cmd_set = (k == 3);
		HOST_EVT.cmd_clr = (k == 4);
		if (k == 3)
			cmd_bit = 1'b1;
		if (k == 4)
			cmd_bit = 1'b0;
		if (k == 5)
			HOST_EVT.host_flags = d[1:0];
		@(negedge REF_CLK);
		HOST_EVT.tx_take = 1'b0;
		HOST_EVT.init = 1'b0;
		HOST_EVT.cmd_set = 1'b0;
		HOST_EVT.cmd_clr = 1'b0;
		HOST_EVT.rx_load = 1'b0;
		HOST_EVT.rx_data = ~d; // Released data never shows the old word
		@(negedge REF_CLK);
	endtask : ev
endmodule : host_model
`default_nettype wire

// [bench/host_port_ctrl_bench.sv]
// Self-checking bench for the core-side host port control and status.
// Assumes host_model on the host-bank side; core bus driven on falling edges.
`timescale 1ns/1ns
`default_nettype none

module host_port_ctrl_bench;
	logic                     REF_CLK, SYS_RST, SOFT_RST, CORE_RD, CORE_WR, IRQ_ACK, CLK_EN;
	logic [15:0]              CORE_ADDR, CORE_WDATA, CORE_RDATA, TX_WORD;
	logic                     TX_FULL, CMD_CLEAR, PORT_ACTIVE, IRQ_REQ;
	logic [1:0]               CORE_FLAGS;
	logic [6:0]               HOST_VECTOR, IRQ_VECTOR, PORT_CTL;
	host_port_pkg::host_evt_s HOST_EVT;
	host_port_pkg::irq_src_e  IRQ_SRC;
	int                       num_errors, tests_run;

	host_port_ctrl host_port_ctrl_inst (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
		.SOFT_RST(SOFT_RST), .CORE_ADDR(CORE_ADDR), .CORE_RD(CORE_RD), .CORE_WR(CORE_WR),
		.CORE_WDATA(CORE_WDATA), .CORE_RDATA(CORE_RDATA), .HOST_EVT(HOST_EVT),
		.HOST_VECTOR(HOST_VECTOR), .TX_WORD(TX_WORD), .TX_FULL(TX_FULL), .CORE_FLAGS(CORE_FLAGS),
		.CMD_CLEAR(CMD_CLEAR), .PORT_ACTIVE(PORT_ACTIVE), .PORT_CTL(PORT_CTL), .IRQ_ACK(IRQ_ACK),
		.IRQ_REQ(IRQ_REQ), .IRQ_SRC(IRQ_SRC), .IRQ_VECTOR(IRQ_VECTOR));
	host_model host_model_inst (.REF_CLK(REF_CLK), .CMD_CLEAR(CMD_CLEAR), .HOST_EVT(HOST_EVT),
		.HOST_VECTOR(HOST_VECTOR));

	// 100 MHz clock
	initial
	begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge REF_CLK);
		CORE_ADDR = a;
		CORE_WDATA = d;
		CORE_WR = 1'b1;
		@(negedge REF_CLK);
		CORE_WR = 1'b0;
	endtask : wr

	// Read data is registered, so it is judged one edge after the address
	task automatic rchk(input logic [15:0] a, input logic [15:0] e);
		@(negedge REF_CLK);
		CORE_ADDR = a;
		CORE_RD = 1'b1;
		@(negedge REF_CLK);
		CORE_RD = 1'b0;
		chk(CORE_RDATA, e);
	endtask : rchk

	task automatic complete_run();
		if (num_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	// Control fields, reserved bits, read-only status, unmapped place
	task automatic t_regs();
		rchk(host_port_pkg::CTRL_ADDR, 16'h0000);
		rchk(host_port_pkg::STATUS_ADDR, 16'h0002);
		wr(host_port_pkg::CTRL_ADDR, 16'hFFFF);
		rchk(host_port_pkg::CTRL_ADDR, 16'h001F);
		chk(16'(CORE_FLAGS), 16'h0003);
		chk(16'(IRQ_REQ), 16'h0000);
		wr(host_port_pkg::STATUS_ADDR, 16'hFFFF);
		rchk(host_port_pkg::STATUS_ADDR, 16'h0002);
		rchk(16'hFFC1, 16'h0000);
		wr(host_port_pkg::CTRL_ADDR, 16'h0000);
	endtask : t_regs

	// Host word into the receive word, then transmit word hand-off
	task automatic t_data();
		host_model_inst.ev(0, 16'hA5C3);
		rchk(host_port_pkg::STATUS_ADDR, 16'h0002);
		wr(host_port_pkg::PORTCTL_ADDR, 16'h0040);
		chk(16'(PORT_ACTIVE), 16'h0001);
		chk(16'(PORT_CTL), 16'h0040);
		host_model_inst.ev(0, 16'hA5C3);
		rchk(host_port_pkg::STATUS_ADDR, 16'h0003);
		rchk(host_port_pkg::RXW_ADDR, 16'hA5C3);
		rchk(host_port_pkg::STATUS_ADDR, 16'h0002);
		wr(host_port_pkg::TXW_ADDR, 16'hBEEF);
		chk(TX_WORD, 16'hBEEF);
		chk(16'(TX_FULL), 16'h0001);
		rchk(host_port_pkg::STATUS_ADDR, 16'h0000);
		host_model_inst.ev(1, 16'h0000);
		rchk(host_port_pkg::STATUS_ADDR, 16'h0002);
		host_model_inst.ev(0, 16'h1111);
		wr(host_port_pkg::TXW_ADDR, 16'h2222);
		host_model_inst.ev(2, 16'h0000);
		rchk(host_port_pkg::STATUS_ADDR, 16'h0002);
	endtask : t_data

	// Priority, command service, host clearing, host flags
	task automatic t_irq();
		wr(host_port_pkg::CTRL_ADDR, 16'h0007);
		repeat (2) @(negedge REF_CLK);
		chk(16'(IRQ_SRC), 16'(host_port_pkg::IRQ_TX));
		host_model_inst.ev(0, 16'h3333);
		host_model_inst.ev(3, 16'h0000);
		chk(16'(IRQ_SRC), 16'(host_port_pkg::IRQ_CMD));
		chk(16'(IRQ_VECTOR), 16'h002A);
		rchk(host_port_pkg::STATUS_ADDR, 16'h0007);
		IRQ_ACK = 1'b1;
		@(negedge REF_CLK);
		chk(16'(CMD_CLEAR), 16'h0001);
		IRQ_ACK = 1'b0;
		repeat (3) @(negedge REF_CLK);
		chk(16'(host_model_inst.cmd_bit), 16'h0000);
		rchk(host_port_pkg::STATUS_ADDR, 16'h0003);
		chk(16'(IRQ_SRC), 16'(host_port_pkg::IRQ_TX));
		wr(host_port_pkg::TXW_ADDR, 16'h0000);
		repeat (2) @(negedge REF_CLK);
		chk(16'(IRQ_SRC), 16'(host_port_pkg::IRQ_RX));
		wr(host_port_pkg::CTRL_ADDR, 16'h0006);
		repeat (2) @(negedge REF_CLK);
		chk(16'(IRQ_REQ), 16'h0000);
		host_model_inst.ev(3, 16'h0000);
		host_model_inst.ev(4, 16'h0000);
		rchk(host_port_pkg::STATUS_ADDR, 16'h0001);
		host_model_inst.ev(5, 16'h0002);
		rchk(host_port_pkg::STATUS_ADDR, 16'h0011);
		host_model_inst.ev(5, 16'h0000);
	endtask : t_irq

	// Software reset returns port to general-purpose mode
	task automatic t_soft();
		SOFT_RST = 1'b1;
		@(negedge REF_CLK);
		SOFT_RST = 1'b0;
		chk(16'(PORT_ACTIVE), 16'h0000);
		rchk(host_port_pkg::PORTCTL_ADDR, 16'h0000);
		rchk(host_port_pkg::STATUS_ADDR, 16'h0002);
		CLK_EN = 1'b0;
		wr(host_port_pkg::CTRL_ADDR, 16'h0018);
		CLK_EN = 1'b1;
		rchk(host_port_pkg::CTRL_ADDR, 16'h0000);
		chk(16'(CORE_FLAGS), 16'h0000);
	endtask : t_soft

	// Main sequence: reset held 6 cycles, then scenarios
	initial
	begin
		{SYS_RST, SOFT_RST, CORE_RD, CORE_WR, IRQ_ACK} = 5'b10000;
		{CORE_ADDR, CORE_WDATA} = 32'h0000_0000;
		CLK_EN = 1'b1;
		num_errors = 0;
		tests_run = 0;
		repeat (6) @(negedge REF_CLK);
		SYS_RST = 1'b0;
		t_regs();
		t_data();
		t_irq();
		t_soft();
		complete_run();
	end

	// Watchdog well beyond the hundred or so cycles the run needs
	initial
	begin
		#50000;
		num_errors++;
		complete_run();
	end
endmodule : host_port_ctrl_bench
`default_nettype wire

// [verilog/host_port_ctrl.sv]
// DSP-side control and status logic of the byte-wide host port.
// Assumes host-bank events arrive on REF_CLK; host pins are outside.
// Operation
// - Reset disables port, pins go GPIO
// - Registers reachable only by the core
// - Separate single-register receive and transmit words
// - Control register 5 bits, resets zero
// - Receive request when enable and full
// - Transmit request when enable and empty
// - Command request when enable and pending
// - Command vector comes from host register
// - Priority: command, transmit, then receive
// - Core flags mirrored to host status
// - Status resets with only empty set
// - Full sets when host word loads
// - Full clears on receive read, reset
// - Host initialize clears receive full
// - Empty sets on take, clears on write
// - Host initialize sets transmit empty
// - Pending mirrors command bit, clears serviced
// - Host clearing command bit clears pending
// - Status shows host flags, reset zero
// - Status reserved bits read zero
// - Port inactive while enable bit clear
`timescale 1ns/1ns
`default_nettype none

module host_port_ctrl #(
	parameter int VEC_W = 7
) (
	// Clock, reset, enable
	input  wire logic                   REF_CLK,
	input  wire logic                   SYS_RST,
	input  wire logic                   CLK_EN,
	input  wire logic                   SOFT_RST,
	// Core register port
	input  wire logic [15:0]            CORE_ADDR,
	input  wire logic                   CORE_RD,
	input  wire logic                   CORE_WR,
	input  wire logic [15:0]            CORE_WDATA,
	output logic      [15:0]            CORE_RDATA,
	// Host-bank side
	input  wire host_port_pkg::host_evt_s HOST_EVT,
	input  wire logic [VEC_W-1:0]       HOST_VECTOR,
	output logic      [15:0]            TX_WORD,
	output logic                        TX_FULL,
	output logic      [1:0]             CORE_FLAGS,
	output logic                        CMD_CLEAR,
	// Port mode
	output logic                        PORT_ACTIVE,
	output logic      [6:0]             PORT_CTL,
	// Interrupts to core
	input  wire logic                   IRQ_ACK,
	output logic                        IRQ_REQ,
	output host_port_pkg::irq_src_e     IRQ_SRC,
	output logic      [VEC_W-1:0]       IRQ_VECTOR
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [4:0]        ctrl_q;
	logic [6:0]        portctl_q;
	logic [15:0]       rxw_q, txw_q;
	logic              full_q, empty_q, pend_q, txfull_q;
	logic [1:0]        hflag_q;
	logic [15:0]       rdata_q;
	logic              irq_q, cmdclr_q;
	host_port_pkg::irq_src_e src_q;
	logic [VEC_W-1:0]  vec_q;

	// ----------------------------------------
	// Address match, shared by write decode, read mux and checks
	// ----------------------------------------
	function automatic logic addr_is(input logic [15:0] addr, input logic [15:0] target);
		addr_is = (addr == target);
	endfunction : addr_is

	// Access decode; bus only reaches core, no host path exists
	wire any_rst  = SYS_RST | SOFT_RST;
	wire wr_ctrl  = CORE_WR & addr_is(CORE_ADDR, host_port_pkg::CTRL_ADDR);
	wire wr_port  = CORE_WR & addr_is(CORE_ADDR, host_port_pkg::PORTCTL_ADDR);
	wire wr_tx    = CORE_WR & addr_is(CORE_ADDR, host_port_pkg::TXW_ADDR);
	wire rd_rx    = CORE_RD & addr_is(CORE_ADDR, host_port_pkg::RXW_ADDR);
	wire active   = portctl_q[host_port_pkg::PORT_EN_BIT];

	// Request levels
	wire rx_lvl  = ctrl_q[host_port_pkg::RX_IE_BIT] & full_q & active;
	wire tx_lvl  = ctrl_q[host_port_pkg::TX_IE_BIT] & empty_q & active;
	wire cmd_lvl = ctrl_q[host_port_pkg::CMD_IE_BIT] & pend_q & active;
	wire cmd_svc = IRQ_ACK & irq_q & (src_q == host_port_pkg::IRQ_CMD);

	// Fixed priority selection
	wire host_port_pkg::irq_src_e src_d =
		cmd_lvl ? host_port_pkg::IRQ_CMD :
		tx_lvl  ? host_port_pkg::IRQ_TX  :
		rx_lvl  ? host_port_pkg::IRQ_RX  : host_port_pkg::IRQ_NONE;

	// Status view, upper bits zero
	wire [15:0] status_w = {11'h000, hflag_q, pend_q, empty_q, full_q};

	// Read mux; unmapped addresses read zero
	wire [15:0] rdata_d =
		addr_is(CORE_ADDR, host_port_pkg::CTRL_ADDR)    ? {11'h000, ctrl_q} :
		addr_is(CORE_ADDR, host_port_pkg::STATUS_ADDR)  ? status_w :
		addr_is(CORE_ADDR, host_port_pkg::PORTCTL_ADDR) ? {9'h000, portctl_q} :
		addr_is(CORE_ADDR, host_port_pkg::RXW_ADDR)     ? rxw_q : 16'h0000;

	// ----------------------------------------
	// Control and port registers
	// ----------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		if (any_rst)
		begin
			ctrl_q    <= host_port_pkg::CTRL_RESET[4:0];
			portctl_q <= host_port_pkg::PORTCTL_RESET[6:0];
		end
		else if (CLK_EN)
		begin
			if (wr_ctrl)
				ctrl_q <= CORE_WDATA[4:0];
			if (wr_port)
				portctl_q <= CORE_WDATA[6:0];
		end
	end

	// Data words: one per direction, so both sides proceed
	always_ff @(posedge REF_CLK)
	begin
		if (any_rst)
		begin
			rxw_q <= 16'h0000;
			txw_q <= 16'h0000;
		end
		else if (CLK_EN)
		begin
			if (HOST_EVT.rx_load & active)
				rxw_q <= HOST_EVT.rx_data;
			if (wr_tx)
				txw_q <= CORE_WDATA;
		end
	end

	// Status flags; a set in the same cycle as a clear wins
	always_ff @(posedge REF_CLK)
	begin
		if (any_rst)
		begin
			full_q  <= host_port_pkg::STATUS_RESET[0];
			empty_q <= host_port_pkg::STATUS_RESET[1];
			txfull_q <= ~host_port_pkg::STATUS_RESET[1];
			pend_q  <= host_port_pkg::STATUS_RESET[2];
			hflag_q <= host_port_pkg::STATUS_RESET[4:3];
		end
		else if (CLK_EN)
		begin
			if (HOST_EVT.rx_load & active)
				full_q <= 1'b1;
			else if (rd_rx | HOST_EVT.init)
				full_q <= 1'b0;
			if ((HOST_EVT.tx_take & active) | HOST_EVT.init)
			begin
				empty_q  <= 1'b1;
				txfull_q <= 1'b0;
			end
			else if (wr_tx)
			begin
				empty_q  <= 1'b0;
				txfull_q <= 1'b1;
			end
			if (HOST_EVT.cmd_set & active)
				pend_q <= 1'b1;
			else if (cmd_svc | HOST_EVT.cmd_clr)
				pend_q <= 1'b0;
			hflag_q <= HOST_EVT.host_flags;
		end
	end

	// Registered outputs; requests follow levels one cycle late
	always_ff @(posedge REF_CLK)
	begin
		if (any_rst)
		begin
			rdata_q  <= 16'h0000;
			irq_q    <= 1'b0;
			src_q    <= host_port_pkg::IRQ_NONE;
			vec_q    <= '0;
			cmdclr_q <= 1'b0;
		end
		else if (CLK_EN)
		begin
			rdata_q  <= rdata_d;
			irq_q    <= (src_d != host_port_pkg::IRQ_NONE);
			src_q    <= src_d;
			vec_q    <= HOST_VECTOR;
			cmdclr_q <= cmd_svc;
		end
	end

	// Output drive
	assign CORE_RDATA = rdata_q;
	assign TX_WORD    = txw_q;
	assign TX_FULL    = txfull_q; // Own flop, so the pin has no inverter
	assign CORE_FLAGS = ctrl_q[host_port_pkg::FLAG_LO +: 2];
	assign CMD_CLEAR  = cmdclr_q;
	assign PORT_ACTIVE = portctl_q[host_port_pkg::PORT_EN_BIT];
	assign PORT_CTL   = portctl_q;
	assign IRQ_REQ    = irq_q;
	assign IRQ_SRC    = src_q;
	assign IRQ_VECTOR = vec_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Request selection; soft reset clears every request, so it gates too
	chk_rx_request: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && rx_lvl && !cmd_lvl && !tx_lvl |=> IRQ_SRC == host_port_pkg::IRQ_RX)
		else $error("receive request not raised");

	chk_tx_request: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && tx_lvl && !cmd_lvl |=> IRQ_SRC == host_port_pkg::IRQ_TX)
		else $error("transmit request not raised");

	chk_cmd_prio: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && cmd_lvl |=> IRQ_REQ && IRQ_SRC == host_port_pkg::IRQ_CMD)
		else $error("command not top priority");

	chk_rx_masked: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && !ctrl_q[host_port_pkg::RX_IE_BIT] && !tx_lvl && !cmd_lvl |=> !IRQ_REQ)
		else $error("receive request while disabled");

	chk_tx_over_rx: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && tx_lvl && rx_lvl && !cmd_lvl |=> IRQ_SRC == host_port_pkg::IRQ_TX)
		else $error("transmit not above receive");

	chk_req_level: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && !rx_lvl && !tx_lvl && !cmd_lvl |=> !IRQ_REQ)
		else $error("request without active source");

	chk_req_raised: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && (rx_lvl || tx_lvl || cmd_lvl) |=> IRQ_REQ)
		else $error("request missing for active source");

	chk_no_irq_off: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && !active |=> !IRQ_REQ)
		else $error("request while port inactive");

	chk_cmd_vector: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN |=> IRQ_VECTOR == $past(HOST_VECTOR))
		else $error("command vector not taken from host");

	// Receive side; a host load in the same cycle beats any clear
	chk_full_set: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && HOST_EVT.rx_load && active |=> full_q && rxw_q == $past(HOST_EVT.rx_data))
		else $error("receive full not set");

	chk_full_clear: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && rd_rx && !HOST_EVT.rx_load |=> !full_q)
		else $error("receive full not cleared");

	chk_init_flags: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && HOST_EVT.init && !HOST_EVT.rx_load |=> empty_q && !full_q)
		else $error("initialize did not reset flags");

	// Transmit side; the pin copy is a separate flop and must track
	chk_tx_load: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && wr_tx |=> TX_WORD == $past(CORE_WDATA))
		else $error("transmit word not loaded");

	chk_empty_clear: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && wr_tx && !HOST_EVT.tx_take && !HOST_EVT.init |=> TX_FULL)
		else $error("transmit empty not cleared");

	chk_empty_set: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && ((HOST_EVT.tx_take && active) || HOST_EVT.init) |=> !TX_FULL)
		else $error("transmit empty not set");

	chk_full_mirror: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		TX_FULL != empty_q)
		else $error("transmit full pin disagrees with flag");

	// Command handshake
	chk_pend_set: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && HOST_EVT.cmd_set && active |=> pend_q)
		else $error("pending not set");

	chk_cmd_service: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && cmd_svc && !HOST_EVT.cmd_set |=> !pend_q && CMD_CLEAR)
		else $error("serviced command not cleared");

	chk_pend_clear: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && HOST_EVT.cmd_clr && !HOST_EVT.cmd_set |=> !pend_q)
		else $error("pending not cleared");

	// Register view
	chk_ctrl_reserved: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && addr_is(CORE_ADDR, host_port_pkg::CTRL_ADDR) |=> CORE_RDATA[15:5] == 11'h000)
		else $error("control reserved bits not zero");

	chk_status_reserved: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && addr_is(CORE_ADDR, host_port_pkg::STATUS_ADDR) |=> CORE_RDATA[15:5] == 11'h000)
		else $error("status reserved bits not zero");

	chk_flag_mirror: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN && wr_ctrl |=> CORE_FLAGS == $past(CORE_WDATA[4:3]))
		else $error("core flags not mirrored");

	chk_host_flags: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		CLK_EN |=> hflag_q == $past(HOST_EVT.host_flags))
		else $error("host flags not reflected");

	// Reset and freeze; a frozen cycle must hold every register, so an event in it is dropped
	chk_reset_state: assert property (@(posedge REF_CLK)
		SYS_RST |=> status_w == host_port_pkg::STATUS_RESET && !PORT_ACTIVE)
		else $error("reset values wrong");

	chk_soft_reset: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		SOFT_RST |=> !PORT_ACTIVE && PORT_CTL == 7'h00 && status_w == host_port_pkg::STATUS_RESET)
		else $error("software reset left port active");

	chk_freeze_ctrl: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		!CLK_EN |=> $stable(ctrl_q) && $stable(portctl_q))
		else $error("control changed while frozen");

	chk_freeze_words: assert property (@(posedge REF_CLK) disable iff (SYS_RST || SOFT_RST)
		!CLK_EN |=> $stable(rxw_q) && $stable(txw_q) && $stable(status_w))
		else $error("data or status changed while frozen");

	// Main scenarios
	cov_cmd_irq:  cover property (@(posedge REF_CLK) IRQ_REQ && IRQ_SRC == host_port_pkg::IRQ_CMD);
	cov_rx_then_read: cover property (@(posedge REF_CLK) full_q ##[1:20] rd_rx);
	cov_tx_cycle: cover property (@(posedge REF_CLK) wr_tx ##[1:20] HOST_EVT.tx_take);
	cov_prio_clash: cover property (@(posedge REF_CLK) cmd_lvl && tx_lvl && rx_lvl);
	cov_freeze:   cover property (@(posedge REF_CLK) !CLK_EN ##1 CLK_EN);

endmodule : host_port_ctrl

`default_nettype wire

// [verilog/host_port_pkg.sv]
// Shared constants and carriers for the DSP-side host port control/status block.
// Assumes a single core clock domain and core-side register access.
package host_port_pkg;

	// ----------------------------------------
	// Register map (core data-space word addresses)
	// ----------------------------------------
	localparam logic [15:0] CTRL_ADDR    = 16'hFFC2;
	localparam logic [15:0] STATUS_ADDR  = 16'hFFC3;
	localparam logic [15:0] PORTCTL_ADDR = 16'hFFC4;
	localparam logic [15:0] RXW_ADDR     = 16'hFFC6;
	localparam logic [15:0] TXW_ADDR     = 16'hFFC7;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int RX_IE_BIT  = 0;
	localparam int TX_IE_BIT  = 1;
	localparam int CMD_IE_BIT = 2;
	localparam int FLAG_LO    = 3;
	localparam int PORT_EN_BIT = 6;
	localparam int PORT_CNT_BITS = 7;
	localparam logic [15:0] CTRL_RESET    = 16'h0000;
	localparam logic [15:0] STATUS_RESET  = 16'h0002;
	localparam logic [15:0] PORTCTL_RESET = 16'h0000;

	// Interrupt source selected for presentation
	typedef enum logic [1:0] {IRQ_NONE, IRQ_CMD, IRQ_TX, IRQ_RX} irq_src_e;

	// Host-side event group, already synchronised by the host bank
	typedef struct packed {
		logic       rx_load;   // Host word moved into receive word
		logic [15:0] rx_data;
		logic       tx_take;   // Transmit word moved to host receive pair
		logic       init;      // Host initialize function
		logic       cmd_set;
		logic       cmd_clr;
		logic [1:0] host_flags;
	} host_evt_s;

endpackage : host_port_pkg
